/* File: shared/cli_pkg.sv */
// Shared constants and types for the coefficient loader, half-band and router
package cli_pkg;
    localparam int COEF_W = 20;
    localparam int ADDR_W = 7;
    localparam int RAM_DEPTH = 128;
    localparam int SAMP_W = 22;
    localparam int NCH = 6;
    localparam int REG_AW = 4;
    localparam int REG_DW = 20;
    // Register offsets
    localparam logic [3:0] REG_TAPS = 4'h0;
    localparam logic [3:0] REG_COEF_OFS = 4'h1;
    localparam logic [3:0] REG_CH_CTRL = 4'h2;
    localparam logic [3:0] REG_START = 4'h3;
    localparam logic [3:0] REG_STOP = 4'h4;
    localparam logic [3:0] REG_MEM_LO = 4'h5;
    localparam logic [3:0] REG_MEM_HI = 4'h6;
    localparam logic [3:0] REG_MONO_CTRL = 4'h7;
    localparam logic [3:0] REG_STREAM = 4'h8;
    localparam logic [3:0] REG_ADDR_PTR = 4'h9;
    // Field positions
    localparam int CTRL_SYM_BIT = 0;
    localparam int CTRL_PHASE_LSB = 4;
    localparam int MONO_HB_EN_BIT = 9;
    localparam int LO_W = 16;
    // Reset values
    localparam logic [19:0] RST_ZERO = 20'h00000;
    localparam logic [3:0] STREAM_RST = 4'hf;
    // Half-band coefficients
    localparam int HB_C1 = 14;
    localparam int HB_C3 = -66;
    localparam int HB_C5 = 309;
    localparam int HB_C6 = 512;
    localparam int HB_SHIFT = 9;

    typedef struct packed {
        logic valid;
        logic [SAMP_W-1:0] i;
        logic [SAMP_W-1:0] q;
    } cli_iq_t;

    typedef enum logic [1:0] {
        CLI_HB_IDLE = 2'b00,
        CLI_HB_EVEN = 2'b01,
        CLI_HB_ODD = 2'b10
    } cli_hb_state_t;
endpackage

/* File: logic/cli_halfband.sv */
// Interpolate-by-two half-band filter on one I/Q stream
`timescale 1ns/1ns
module cli_halfband (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic enable,
    input wire cli_pkg::cli_iq_t din,
    output cli_pkg::cli_iq_t dout
);
    import cli_pkg::*;

    logic signed [SAMP_W-1:0] di_q [0:5];
    logic signed [SAMP_W-1:0] dq_q [0:5];
    cli_hb_state_t st_q;
    cli_iq_t out_q;

    // Odd phase taps 14, -66, 309, 309, -66, 14 over six samples
    function automatic logic [SAMP_W-1:0] odd_tap(input logic signed [SAMP_W-1:0] s [0:5]);
        logic signed [SAMP_W+12:0] acc;
        logic signed [SAMP_W+12:0] r;
        acc = (SAMP_W+13)'(HB_C1) * (s[0] + s[5]) + (SAMP_W+13)'(HB_C3) * (s[1] + s[4])
            + (SAMP_W+13)'(HB_C5) * (s[2] + s[3]);
        r = (acc + (SAMP_W+13)'(1 << (HB_SHIFT - 1))) >>> HB_SHIFT;
        if (r > (SAMP_W+13)'(2 ** (SAMP_W - 1) - 1)) begin
            odd_tap = {1'b0, {(SAMP_W-1){1'b1}}};
        end else if (r < -(SAMP_W+13)'(2 ** (SAMP_W - 1))) begin
            odd_tap = {1'b1, {(SAMP_W-1){1'b0}}};
        end else begin
            odd_tap = r[SAMP_W-1:0];
        end
    endfunction

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int k = 0; k < 6; k++) begin
                di_q[k] <= '0;
                dq_q[k] <= '0;
            end
        end else if (din.valid) begin
            di_q[0] <= din.i;
            dq_q[0] <= din.q;
            for (int k = 1; k < 6; k++) begin
                di_q[k] <= di_q[k-1];
                dq_q[k] <= dq_q[k-1];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= CLI_HB_IDLE;
            out_q <= '0;
        end else begin
            out_q.valid <= 1'b0;
            case (st_q)
                CLI_HB_IDLE: begin
                    if (din.valid && !enable) begin
                        out_q <= din;
                    end else if (din.valid) begin
                        st_q <= CLI_HB_EVEN;
                    end
                end
                CLI_HB_EVEN: begin
                    // centre tap 512 is pure delay
                    out_q.valid <= 1'b1;
                    out_q.i <= di_q[3];
                    out_q.q <= dq_q[3];
                    st_q <= CLI_HB_ODD;
                end
                CLI_HB_ODD: begin
                    out_q.valid <= 1'b1;
                    out_q.i <= odd_tap(di_q);
                    out_q.q <= odd_tap(dq_q);
                    st_q <= CLI_HB_IDLE;
                end
                default: st_q <= CLI_HB_IDLE;
            endcase
        end
    end

    assign dout = out_q;
endmodule

/* File: logic/cli_router.sv */
// Output router interleaving channel streams per stream-select code
`timescale 1ns/1ns
module cli_router (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] stream_sel,
    input wire cli_pkg::cli_iq_t ch_in [0:cli_pkg::NCH-1],
    output cli_pkg::cli_iq_t st_out [0:cli_pkg::NCH-1]
);
    import cli_pkg::*;

    logic [2:0] grp [0:NCH-1];
    cli_iq_t out_q [0:NCH-1];

    // Group leader index of each channel for a code
    function automatic logic [2:0] leader(input logic [3:0] code, input int ch);
        logic [2:0] l;
        l = 3'(ch);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: if (ch <= int'(code) + 1) l = 3'h0;
            4'h5: l = (ch < 3) ? 3'h0 : 3'h3;
            4'h6: l = 3'(ch & 6);
            4'h7: if (ch < 4) l = 3'(ch & 6);
            4'h8: if (ch < 3) l = 3'h0; else if (ch < 5) l = 3'h3;
            4'h9: l = (ch < 4) ? 3'h0 : 3'h4;
            default: l = 3'(ch);
        endcase
        leader = l;
    endfunction

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            grp[c] = leader(stream_sel, c);
        end
    end

    // phases arrive alternately, forwarded in order
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int s = 0; s < NCH; s++) begin
                out_q[s] <= '0;
            end
        end else begin
            for (int s = 0; s < NCH; s++) begin
                out_q[s].valid <= 1'b0;
                for (int c = NCH - 1; c >= 0; c--) begin
                    if (ch_in[c].valid && grp[c] == 3'(s)) begin
                        out_q[s] <= ch_in[c];
                    end
                end
            end
        end
    end

    assign st_out = out_q;
endmodule

/* File: logic/cli_top.sv */
// Coefficient RAM loader, half-band interpolators and output router
`timescale 1ns/1ns
module cli_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [cli_pkg::REG_AW-1:0] reg_addr,
    input wire logic [cli_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cli_pkg::REG_DW-1:0] reg_rdata,
    input wire cli_pkg::cli_iq_t ch_in [0:cli_pkg::NCH-1],
    output cli_pkg::cli_iq_t st_out [0:cli_pkg::NCH-1],
    output logic [cli_pkg::ADDR_W:0] tap_count,
    output logic [cli_pkg::ADDR_W-1:0] coef_offset,
    output logic sym_en,
    output logic [3:0] dec_phase,
    input wire logic [cli_pkg::ADDR_W-1:0] coef_rd_addr,
    output logic [cli_pkg::COEF_W-1:0] coef_rd_data
);
    import cli_pkg::*;

    logic [ADDR_W-1:0] taps_q;
    logic [ADDR_W-1:0] ofs_q;
    logic [REG_DW-1:0] ctrl_q;
    logic [ADDR_W-1:0] start_q;
    logic [ADDR_W-1:0] stop_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [LO_W-1:0] lo_q;
    logic [REG_DW-1:0] mono_q;
    logic [3:0] stream_q;
    logic [COEF_W-1:0] ram_q [0:RAM_DEPTH-1];
    logic [REG_DW-1:0] rdata_q;
    logic [COEF_W-1:0] crd_q;
    logic mem_hit;
    cli_iq_t hb_out [0:NCH-1];

    assign mem_hit = (reg_wr && reg_addr == REG_MEM_HI) || (reg_rd && reg_addr == REG_MEM_HI);

    // Configuration registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            taps_q <= RST_ZERO[ADDR_W-1:0];
            ofs_q <= RST_ZERO[ADDR_W-1:0];
            ctrl_q <= RST_ZERO;
            start_q <= RST_ZERO[ADDR_W-1:0];
            stop_q <= RST_ZERO[ADDR_W-1:0];
            mono_q <= RST_ZERO;
            stream_q <= STREAM_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_TAPS: taps_q <= reg_wdata[ADDR_W-1:0];
                REG_COEF_OFS: ofs_q <= reg_wdata[ADDR_W-1:0];
                REG_CH_CTRL: ctrl_q <= reg_wdata;
                REG_START: start_q <= reg_wdata[ADDR_W-1:0];
                REG_STOP: stop_q <= reg_wdata[ADDR_W-1:0];
                REG_MONO_CTRL: mono_q <= reg_wdata;
                REG_STREAM: stream_q <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // low 16 bits held until high part written
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lo_q <= RST_ZERO[LO_W-1:0];
        end else if (reg_wr && reg_addr == REG_MEM_LO) begin
            lo_q <= reg_wdata[LO_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ptr_q <= RST_ZERO[ADDR_W-1:0];
        end else if (reg_wr && reg_addr == REG_START) begin
            ptr_q <= reg_wdata[ADDR_W-1:0];
        end else if (mem_hit && ptr_q != stop_q) begin
            ptr_q <= ptr_q + 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int k = 0; k < RAM_DEPTH; k++) begin
                ram_q[k] <= RST_ZERO;
            end
        end else if (reg_wr && reg_addr == REG_MEM_HI) begin
            ram_q[ptr_q] <= {reg_wdata[COEF_W-LO_W-1:0], lo_q};
        end
    end

    // Register read port, data one cycle later
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= RST_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_TAPS: rdata_q <= {13'h0000, taps_q};
                REG_COEF_OFS: rdata_q <= {13'h0000, ofs_q};
                REG_CH_CTRL: rdata_q <= ctrl_q;
                REG_START: rdata_q <= {13'h0000, start_q};
                REG_STOP: rdata_q <= {13'h0000, stop_q};
                REG_MEM_LO: rdata_q <= {4'h0, ram_q[ptr_q][LO_W-1:0]};
                REG_MEM_HI: rdata_q <= {16'h0000, ram_q[ptr_q][COEF_W-1:LO_W]};
                REG_MONO_CTRL: rdata_q <= mono_q;
                REG_STREAM: rdata_q <= {16'h0000, stream_q};
                REG_ADDR_PTR: rdata_q <= {13'h0000, ptr_q};
                default: rdata_q <= RST_ZERO;
            endcase
        end else begin
            rdata_q <= RST_ZERO;
        end
    end
    assign reg_rdata = rdata_q;

    // Coefficient fetch for the channel filter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            crd_q <= RST_ZERO;
        end else begin
            crd_q <= ram_q[coef_rd_addr];
        end
    end
    assign coef_rd_data = crd_q;

    // stored value plus one is tap count
    assign tap_count = {1'b0, taps_q} + 8'h01;
    assign coef_offset = ofs_q;
    assign sym_en = ctrl_q[CTRL_SYM_BIT];
    assign dec_phase = ctrl_q[CTRL_PHASE_LSB+3:CTRL_PHASE_LSB];

    for (genvar g = 0; g < NCH; g++) begin : g_hb
        cli_halfband u_hb (
            .sys_clk(sys_clk),
            .reset(reset),
            .enable(mono_q[MONO_HB_EN_BIT]),
            .din(ch_in[g]),
            .dout(hb_out[g])
        );
    end

    cli_router u_router (
        .sys_clk(sys_clk),
        .reset(reset),
        .stream_sel(stream_q),
        .ch_in(hb_out),
        .st_out(st_out)
    );
endmodule

/* File: verification/cli_top_asserts.sv */
// Port-level checks for the coefficient loader, half-band and router
`timescale 1ns/1ns
module cli_top_asserts
    import cli_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [cli_pkg::REG_AW-1:0] reg_addr,
    input wire logic [cli_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [cli_pkg::REG_DW-1:0] reg_rdata,
    input wire cli_pkg::cli_iq_t ch_in [0:cli_pkg::NCH-1],
    input wire cli_pkg::cli_iq_t st_out [0:cli_pkg::NCH-1],
    input wire logic [cli_pkg::ADDR_W:0] tap_count,
    input wire logic [cli_pkg::ADDR_W-1:0] coef_offset,
    input wire logic sym_en,
    input wire logic [3:0] dec_phase
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic hb_en_q;
    logic [3:0] stream_q;
    logic indep;
    assign indep = stream_q > 4'h9;
    // Shadow of half-band enable and stream select
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hb_en_q <= 1'b0;
            stream_q <= STREAM_RST;
        end else if (reg_wr && reg_addr == REG_MONO_CTRL) begin
            hb_en_q <= reg_wdata[MONO_HB_EN_BIT];
        end else if (reg_wr && reg_addr == REG_STREAM) begin
            stream_q <= reg_wdata[3:0];
        end
    end
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    AST_RD_UNMAPPED: assert property (reg_rd && reg_addr > REG_ADDR_PTR |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    AST_TAPS: assert property (reg_wr && reg_addr == REG_TAPS |=> tap_count == {1'b0, $past(reg_wdata[6:0])} + 8'h01)
        else $error("tap count not register plus one");
    AST_OFS: assert property (reg_wr && reg_addr == REG_COEF_OFS |=> coef_offset == $past(reg_wdata[6:0]))
        else $error("coefficient offset not loaded");
    AST_CTRL: assert property (reg_wr && reg_addr == REG_CH_CTRL
        |=> sym_en == $past(reg_wdata[0]) && dec_phase == $past(reg_wdata[7:4]))
        else $error("control fields not loaded");
    AST_PTR_LOAD: assert property (reg_wr && reg_addr == REG_START ##1 reg_rd && reg_addr == REG_ADDR_PTR
        |=> reg_rdata == {13'h0, $past(reg_wdata[6:0], 2)})
        else $error("start write did not load pointer");
    AST_HB_PASS: assert property (!hb_en_q && indep && ch_in[0].valid
        |-> ##2 st_out[0].valid && st_out[0].i == $past(ch_in[0].i, 2))
        else $error("disabled half-band not passing through");
    AST_HB_DOUBLE: assert property (hb_en_q && indep && ch_in[0].valid
        |-> ##3 st_out[0].valid ##1 st_out[0].valid)
        else $error("half-band did not give two outputs");
    cover property (hb_en_q && st_out[0].valid);
    cover property (stream_q == 4'h4 && st_out[0].valid);
    cover property (reg_wr && reg_addr == REG_MEM_HI);
endmodule
bind cli_top cli_top_asserts i_chk (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ch_in, .st_out, .tap_count, .coef_offset, .sym_en, .dec_phase);

/* File: verification/cli_gain_sink.sv */
// Downstream gain-loop stand-in that records routed samples
`timescale 1ns/1ns
module cli_gain_sink
    import cli_pkg::*;
(
    input wire logic sys_clk,
    input wire logic clear,
    input wire cli_pkg::cli_iq_t st_out [0:cli_pkg::NCH-1],
    output int cnt [0:cli_pkg::NCH-1],
    output cli_pkg::cli_iq_t last [0:cli_pkg::NCH-1],
    output cli_pkg::cli_iq_t prev [0:cli_pkg::NCH-1]
);
    always_ff @(posedge sys_clk) begin
        for (int s = 0; s < NCH; s++) begin
            if (clear) begin
                cnt[s] <= 0;
            end else if (st_out[s].valid) begin
                cnt[s] <= cnt[s] + 1;
                prev[s] <= last[s];
                last[s] <= st_out[s];
            end
        end
    end
endmodule

/* File: verification/cli_top_bench.sv */
// Register, coefficient, half-band and router tests
`timescale 1ns/1ns
module cli_top_bench;
    import cli_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [REG_DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_DW-1:0] reg_rdata;
    cli_iq_t ch_in [0:NCH-1] = '{default: '0};
    cli_iq_t st_out [0:NCH-1];
    cli_iq_t last [0:NCH-1];
    cli_iq_t prev [0:NCH-1];
    int cnt [0:NCH-1];
    logic [ADDR_W:0] tap_count;
    logic [ADDR_W-1:0] coef_offset;
    logic sym_en;
    logic [3:0] dec_phase;
    logic [ADDR_W-1:0] coef_rd_addr = '0;
    logic [COEF_W-1:0] coef_rd_data;
    logic clear = 1'b0;
    int errors = 0;
    int n_compared = 0;
    logic [19:0] ram_exp [0:2] = '{20'h11230, 20'habcde, 20'h41233};
    logic [3:0] codes [0:11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hf};
    logic [23:0] exps [0:11] = '{24'h201111, 24'h300111, 24'h400011, 24'h500001, 24'h600000, 24'h300300,
        24'h202020, 24'h202011, 24'h300201, 24'h400020, 24'h111111, 24'h111111};

    always #10 sys_clk = ~sys_clk;

    cli_top i_dut (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ch_in, .st_out,
        .tap_count, .coef_offset, .sym_en, .dec_phase, .coef_rd_addr, .coef_rd_data);
    cli_gain_sink i_sink (.sys_clk, .clear, .st_out, .cnt, .last, .prev);

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [19:0] d);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [19:0] e);
        bus(1'b0, 1'b1, a, '0);
        bus(1'b0, 1'b0, a, '0);
        #1;
        cmp("reg_rdata", e, reg_rdata);
    endtask
    task automatic ch(input int k, input logic [21:0] i, input logic [21:0] q);
        @(posedge sys_clk);
        ch_in[k] <= {1'b1, i, q};
        @(posedge sys_clk);
        ch_in[k].valid <= 1'b0;
    endtask
    task automatic feed(input int n, input logic [21:0] x);
        repeat (n) begin
            ch(0, x, -x);
            repeat (2) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic clr;
        @(posedge sys_clk);
        clear <= 1'b1;
        @(posedge sys_clk);
        clear <= 1'b0;
    endtask
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rdchk(REG_STREAM, 20'h0000f);
        rdchk(4'hc, 20'h00000);
        bus(1'b1, 1'b0, REG_TAPS, 20'd19);
        bus(1'b1, 1'b0, REG_COEF_OFS, 20'h36);
        bus(1'b1, 1'b0, REG_CH_CTRL, 20'h31);
        bus(1'b0, 1'b0, '0, '0);
        #1;
        cmp("tap_count", 20, tap_count);
        cmp("coef_offset", 'h36, coef_offset);
        cmp("sym_en", 1, sym_en);
        cmp("dec_phase", 3, dec_phase);
        $display("test registers done");
        bus(1'b1, 1'b0, REG_START, 20'h36);
        bus(1'b0, 1'b1, REG_ADDR_PTR, '0);
        bus(1'b1, 1'b0, REG_STOP, 20'h38);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 1'b0, REG_MEM_LO, 20'h01230 + k);
            bus(1'b1, 1'b0, REG_MEM_HI, 20'(k + 1));
        end
        rdchk(REG_ADDR_PTR, 20'h38);
        bus(1'b1, 1'b0, REG_START, 20'h37);
        bus(1'b1, 1'b0, REG_STOP, 20'h37);
        bus(1'b1, 1'b0, REG_MEM_LO, 20'h0bcde);
        bus(1'b1, 1'b0, REG_MEM_HI, 20'h0000a);
        bus(1'b0, 1'b0, '0, '0);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            coef_rd_addr <= 7'h36 + 7'(k);
            @(posedge sys_clk);
            #1;
            cmp("coef_rd_data", ram_exp[k], coef_rd_data);
        end
        $display("test coefficients done");
        clr;
        feed(4, 22'd512);
        cmp("pass count", 4, cnt[0]);
        cmp("pass sample", 512, last[0].i);
        bus(1'b1, 1'b0, REG_MONO_CTRL, 20'h00200);
        bus(1'b0, 1'b0, '0, '0);
        clr;
        feed(8, 22'd512);
        cmp("interp count", 16, cnt[0]);
        cmp("odd sample", 514, last[0].i);
        cmp("even sample", 512, prev[0].i);
        cmp("odd q", 22'h3ffdfe, last[0].q);
        bus(1'b1, 1'b0, REG_MONO_CTRL, '0);
        $display("test halfband done");
        for (int c = 0; c < 12; c++) begin
            bus(1'b1, 1'b0, REG_STREAM, {16'h0, codes[c]});
            bus(1'b0, 1'b0, '0, '0);
            clr;
            for (int k = 0; k < NCH; k++) ch(k, 22'(k), '0);
            repeat (4) @(posedge sys_clk);
            for (int s = 0; s < NCH; s++) cmp("stream count", exps[c][23 - 4 * s -: 4], cnt[s]);
            cmp("stream order", exps[c][23:20] - 4'h1, last[0].i);
        end
        $display("test router done");
        test_done;
    end

    initial begin
        #200_000;
        errors++;
        test_done;
    end
endmodule
